// ===== design/tmg_guard.sv
// Page access guard with identifier and tap counter text overlay
`timescale 1ns/1ps
module tmg_guard #(
    parameter logic [255:0] SIGNATURE = 256'h0123_4567_89AB_CDEF_0123_4567_89AB_CDEF_0123_4567_89AB_CDEF_0123_4567_89AB_CDEF
)(
    input wire logic clk_sys,
    input wire logic rst,
    input tmg_pkg::tmg_req_s req,
    input wire logic [55:0] uidBytes,
    input wire logic [23:0] tapCount,
    output tmg_pkg::tmg_rsp_s rsp,
    output logic sessionAuthed,
    output logic guardLocked,
    output logic [2:0] failCount,
    output logic tapCounterEnable,
    output logic [7:0] firstGuardedPage
);
    // SIGNATURE value above is arbitrary

    typedef struct packed {
        logic [tmg_pkg::ARRAY_PAGES-1:0][31:0] mem;
        logic [31:0] mirrorCfg;
        logic [31:0] accessCfg;
        logic [31:0] keyWord;
        logic [15:0] ackWord;
        logic [2:0] failCnt;
        logic locked;
        logic authed;
        tmg_pkg::tmg_rsp_s rsp;
    } tmg_state_s;

    tmg_state_s state_ff;
    tmg_state_s nxt_state;

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    logic [1:0] overlaySelect;
    logic [1:0] mirrorByte;
    logic [7:0] mirrorPage;
    logic guardLevelBit;
    logic configFreezeBit;
    logic counterAuthGuard;
    logic [2:0] failedTryLimit;

    assign overlaySelect = state_ff.mirrorCfg[tmg_pkg::SEL_HI:tmg_pkg::SEL_LO];
    assign mirrorByte = state_ff.mirrorCfg[tmg_pkg::MBYTE_HI:tmg_pkg::MBYTE_LO];
    assign mirrorPage = state_ff.mirrorCfg[tmg_pkg::MPAGE_HI:tmg_pkg::MPAGE_LO];
    assign firstGuardedPage = state_ff.mirrorCfg[tmg_pkg::FGP_HI:tmg_pkg::FGP_LO];
    assign guardLevelBit = state_ff.accessCfg[tmg_pkg::LEVEL_BIT];
    assign configFreezeBit = state_ff.accessCfg[tmg_pkg::FREEZE_BIT];
    assign tapCounterEnable = state_ff.accessCfg[tmg_pkg::CNT_EN_BIT];
    assign counterAuthGuard = state_ff.accessCfg[tmg_pkg::CNT_GUARD_BIT];
    assign failedTryLimit = state_ff.accessCfg[tmg_pkg::LIMIT_HI:tmg_pkg::LIMIT_LO];

    assign rsp = state_ff.rsp;
    assign sessionAuthed = state_ff.authed;
    assign guardLocked = state_ff.locked;
    assign failCount = state_ff.failCnt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        if (nib < tmg_pkg::TEN)
        begin
            hex_char = tmg_pkg::DIGIT_BASE + {4'h0, nib};
        end
        else
        begin
            hex_char = tmg_pkg::LETTER_BASE + {4'h0, nib};
        end
    endfunction : hex_char

    // Text character k of the overlay, MSB nibble first
    function automatic logic [7:0] overlay_char(
        input logic [9:0] k,
        input logic [55:0] uid,
        input logic [23:0] cnt
    );
        logic [9:0] c;
        logic [7:0] b;
        c = 10'h000;
        b = 8'h00;
        if (k < tmg_pkg::UID_CHARS)
        begin
            b = uid[8'(k[9:1]) * 8 +: 8];
        end
        else if (k != tmg_pkg::SEP_POS)
        begin
            c = k - tmg_pkg::CNT_FIRST;
            b = cnt[8'(2 - c[9:1]) * 8 +: 8];
        end
        if (k == tmg_pkg::SEP_POS)
        begin
            overlay_char = tmg_pkg::SEP_CHAR;
        end
        else if (k < tmg_pkg::UID_CHARS)
        begin
            overlay_char = hex_char(k[0] ? b[3:0] : b[7:4]);
        end
        else
        begin
            overlay_char = hex_char(c[0] ? b[3:0] : b[7:4]);
        end
    endfunction : overlay_char

    // ----------------------------------------------------------------
    // Overlay of the addressed page
    // ----------------------------------------------------------------
    logic [9:0] startAddr;
    logic overlayOn;
    logic counterShown;
    logic [31:0] pageRaw;
    logic [31:0] pageView;

    assign startAddr = {mirrorPage, mirrorByte};
    // whole 21 bytes must fit below the last user page end
    assign overlayOn = (mirrorPage > tmg_pkg::MIN_MIRROR_PAGE) &&
        (overlaySelect == tmg_pkg::SEL_COMBINED) &&
        ({2'b00, startAddr} + {2'b00, tmg_pkg::OVERLAY_LEN} <=
         {2'b00, tmg_pkg::LAST_USER_PAGE + 8'h01, 2'b00});
    assign counterShown = !counterAuthGuard || state_ff.authed;

    always_comb
    begin
        logic [9:0] addr;
        logic [9:0] k;
        addr = 10'h000;
        k = 10'h000;
        pageRaw = 32'h0000_0000;
        if (req.page < 8'(tmg_pkg::ARRAY_PAGES))
        begin
            pageRaw = state_ff.mem[req.page[5:0]];
        end
        else if (req.page == tmg_pkg::MIRROR_CFG_PAGE)
        begin
            pageRaw = state_ff.mirrorCfg;
        end
        else if (req.page == tmg_pkg::ACCESS_CFG_PAGE)
        begin
            pageRaw = state_ff.accessCfg;
        end
        // Key and acknowledge pages fall through as zero bytes
        pageView = pageRaw;
        for (int b = 0; b < 4; b++)
        begin
            addr = {req.page, 2'(b)};
            k = addr - startAddr;
            if (overlayOn && addr >= startAddr && k < tmg_pkg::OVERLAY_LEN &&
                (k < tmg_pkg::CNT_FIRST || counterShown))
            begin
                pageView[b*8 +: 8] = overlay_char(k, uidBytes, tapCount);
            end
        end
    end

    // ----------------------------------------------------------------
    // Command handling
    // ----------------------------------------------------------------
    logic pageGuarded;
    logic inRange;
    assign pageGuarded = req.page >= firstGuardedPage;
    assign inRange = req.page <= tmg_pkg::ACK_PAGE;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.rsp.valid = 1'b0;
        if (req.valid)
        begin
            nxt_state.rsp.valid = 1'b1;
            nxt_state.rsp.ack = 1'b0;
            nxt_state.rsp.nak = tmg_pkg::NAK_ARG;
            nxt_state.rsp.data = 32'h0000_0000;
            unique case (req.kind)
                tmg_pkg::CMD_READ:
                begin
                    // read denied only at the read/write level
                    if (inRange && !(pageGuarded && guardLevelBit && !state_ff.authed))
                    begin
                        nxt_state.rsp.ack = 1'b1;
                        nxt_state.rsp.data = pageView;
                    end
                end
                tmg_pkg::CMD_WRITE, tmg_pkg::CMD_LEGACY:
                begin
                    if (inRange && req.page >= tmg_pkg::FIRST_USER_PAGE &&
                        !(pageGuarded && !state_ff.authed))
                    begin
                        nxt_state.rsp.ack = 1'b1;
                        if (req.page < 8'(tmg_pkg::ARRAY_PAGES))
                        begin
                            nxt_state.mem[req.page[5:0]] = req.data;
                        end
                        else if (req.page == tmg_pkg::KEY_PAGE)
                        begin
                            nxt_state.keyWord = req.data;
                        end
                        else if (req.page == tmg_pkg::ACK_PAGE)
                        begin
                            nxt_state.ackWord = req.data[15:0];
                        end
                        else if (configFreezeBit)
                        begin
                            nxt_state.rsp.ack = 1'b0;
                        end
                        else if (req.page == tmg_pkg::MIRROR_CFG_PAGE)
                        begin
                            nxt_state.mirrorCfg = req.data;
                        end
                        else
                        begin
                            nxt_state.accessCfg = req.data;
                        end
                    end
                end
                tmg_pkg::CMD_KEY:
                begin
                    if (state_ff.locked)
                    begin
                        nxt_state.rsp.nak = tmg_pkg::NAK_LOCKED;
                    end
                    else if (req.data == state_ff.keyWord)
                    begin
                        nxt_state.authed = 1'b1;
                        nxt_state.failCnt = tmg_pkg::LIMIT_OFF;
                        nxt_state.rsp.ack = 1'b1;
                        nxt_state.rsp.data = {16'h0000, state_ff.ackWord};
                    end
                    else
                    begin
                        nxt_state.authed = 1'b0;
                        // Counter and lock commit in one register update, so a
                        // cut cycle never leaves a half-counted failure
                        if (failedTryLimit != tmg_pkg::LIMIT_OFF)
                        begin
                            if (state_ff.failCnt >= failedTryLimit)
                            begin
                                nxt_state.locked = 1'b1;
                            end
                            else
                            begin
                                nxt_state.failCnt = state_ff.failCnt + 3'h1;
                            end
                        end
                    end
                end
                tmg_pkg::CMD_SIG:
                begin
                    nxt_state.rsp.ack = 1'b1;
                    nxt_state.rsp.data = SIGNATURE[req.page[2:0] * 32 +: 32];
                end
                tmg_pkg::CMD_DESEL:
                begin
                    nxt_state.authed = 1'b0;
                    nxt_state.rsp.ack = 1'b1;
                end
                default:
                begin
                    nxt_state.rsp.ack = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= '0;
            state_ff.mirrorCfg <= tmg_pkg::MIRROR_CFG_RESET;
            state_ff.accessCfg <= tmg_pkg::ACCESS_CFG_RESET;
            state_ff.keyWord <= tmg_pkg::KEY_RESET;
            state_ff.ackWord <= tmg_pkg::ACK_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

endmodule : tmg_guard

// ===== design/tmg_pkg.sv
// Constants, field layouts and carrier types for the tag mirror and password guard
package tmg_pkg;

    // ----------------------------------------------------------------
    // Memory map
    // ----------------------------------------------------------------
    localparam logic [7:0] FIRST_USER_PAGE = 8'h04;
    localparam logic [7:0] LAST_USER_PAGE = 8'h27;
    localparam logic [7:0] DYN_LOCK_PAGE = 8'h28;
    localparam logic [7:0] MIRROR_CFG_PAGE = 8'h29;
    localparam logic [7:0] ACCESS_CFG_PAGE = 8'h2A;
    localparam logic [7:0] KEY_PAGE = 8'h2B;
    localparam logic [7:0] ACK_PAGE = 8'h2C;
    localparam int ARRAY_PAGES = 41;
    localparam int SIG_WORDS = 8;

    // ----------------------------------------------------------------
    // Field positions in the two configuration words (byte 0 in bits 7:0)
    // ----------------------------------------------------------------
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int MBYTE_HI = 5;
    localparam int MBYTE_LO = 4;
    localparam int MPAGE_HI = 23;
    localparam int MPAGE_LO = 16;
    localparam int FGP_HI = 31;
    localparam int FGP_LO = 24;
    localparam int LEVEL_BIT = 7;
    localparam int FREEZE_BIT = 6;
    localparam int CNT_EN_BIT = 4;
    localparam int CNT_GUARD_BIT = 3;
    localparam int LIMIT_HI = 2;
    localparam int LIMIT_LO = 0;

    localparam logic [31:0] MIRROR_CFG_RESET = 32'hFF00_0004;
    localparam logic [31:0] ACCESS_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] KEY_RESET = 32'hFFFF_FFFF;
    localparam logic [15:0] ACK_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Overlay layout
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_COMBINED = 2'h3;
    localparam logic [7:0] MIN_MIRROR_PAGE = 8'h03;
    localparam logic [9:0] OVERLAY_LEN = 10'h015;
    localparam logic [9:0] UID_CHARS = 10'h00E;
    localparam logic [9:0] SEP_POS = 10'h00E;
    localparam logic [9:0] CNT_FIRST = 10'h00F;
    localparam logic [7:0] SEP_CHAR = 8'h78;
    localparam logic [7:0] DIGIT_BASE = 8'h30;
    localparam logic [7:0] LETTER_BASE = 8'h37;
    localparam logic [3:0] TEN = 4'hA;

    // ----------------------------------------------------------------
    // Answer codes and limits
    // ----------------------------------------------------------------
    localparam logic [3:0] NAK_ARG = 4'h0;
    localparam logic [3:0] NAK_LOCKED = 4'h4;
    localparam logic [2:0] LIMIT_OFF = 3'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [5:0] {
        CMD_READ   = 6'h01,
        CMD_WRITE  = 6'h02,
        CMD_LEGACY = 6'h04,
        CMD_KEY    = 6'h08,
        CMD_SIG    = 6'h10,
        CMD_DESEL  = 6'h20
    } tmg_cmd_e;

    typedef struct packed {
        logic valid;
        tmg_cmd_e kind;
        logic [7:0] page;
        logic [31:0] data;
    } tmg_req_s;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [3:0] nak;
        logic [31:0] data;
    } tmg_rsp_s;

endpackage : tmg_pkg

// ===== test/tmg_guard_properties.sv
// Port-level checks on the page guard
`timescale 1ns/1ps
module tmg_guard_properties (
    input wire logic clk_sys,
    input wire logic rst,
    input tmg_pkg::tmg_req_s req,
    input tmg_pkg::tmg_rsp_s rsp,
    input wire logic sessionAuthed,
    input wire logic guardLocked,
    input wire logic [2:0] failCount,
    input wire logic [7:0] firstGuardedPage
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_key;
        req.valid && req.kind == tmg_pkg::CMD_KEY;
    endsequence
    sequence s_acked;
        rsp.valid && rsp.ack;
    endsequence
    property p_answer;
        req.valid |=> rsp.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_quiet;
        !req.valid |=> !rsp.valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_lock_nak;
        guardLocked && req.valid && req.kind == tmg_pkg::CMD_KEY |=> !rsp.ack && rsp.nak == 4'h4;
    endproperty
    a_lock_nak: assert property (p_lock_nak) else $error("locked key check not 4h");
    property p_lock_hold;
        guardLocked |=> guardLocked;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lockout released");
    property p_clear;
        s_key ##1 s_acked |-> failCount == 3'h0 && sessionAuthed;
    endproperty
    a_clear: assert property (p_clear) else $error("success kept failures");
    property p_ack_word;
        s_key ##1 s_acked |-> rsp.data[31:16] == 16'h0000;
    endproperty
    a_ack_word: assert property (p_ack_word) else $error("ack word too wide");
    property p_count;
        !(req.valid && req.kind == tmg_pkg::CMD_KEY) |=> failCount == $past(failCount);
    endproperty
    a_count: assert property (p_count) else $error("failure count moved");
    property p_key_zero;
        req.valid && req.kind == tmg_pkg::CMD_READ && req.page inside {8'h2B, 8'h2C}
            |=> rsp.data == 32'h0000_0000;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key bytes revealed");
    property p_fgp_reset;
        $past(rst) |-> firstGuardedPage == 8'hFF;
    endproperty
    a_fgp_reset: assert property (p_fgp_reset) else $error("guard page not FFh");
    property p_desel;
        req.valid && req.kind == tmg_pkg::CMD_DESEL |=> !sessionAuthed && rsp.ack;
    endproperty
    a_desel: assert property (p_desel) else $error("session kept");
    property p_nak4;
        rsp.valid && !rsp.ack && rsp.nak == 4'h4 |-> $past(guardLocked);
    endproperty
    a_nak4: assert property (p_nak4) else $error("code 4h while open");
endmodule : tmg_guard_properties

bind tmg_guard tmg_guard_properties i_tmg_guard_properties (.clk_sys(clk_sys), .rst(rst),
    .req(req), .rsp(rsp), .sessionAuthed(sessionAuthed), .guardLocked(guardLocked),
    .failCount(failCount), .firstGuardedPage(firstGuardedPage));

// ===== test/tmg_reader.sv
// Reader model issuing one page command at a time
`timescale 1ns/1ps
module tmg_reader (
    input wire logic clk_sys,
    output tmg_pkg::tmg_req_s req,
    input tmg_pkg::tmg_rsp_s rsp
);
    initial req = '0;
    task automatic xfer(input tmg_pkg::tmg_cmd_e k, input logic [7:0] p,
        input logic [31:0] d, output tmg_pkg::tmg_rsp_s r);
        int n;
        @(negedge clk_sys);
        req <= '{1'b1, k, p, d};
        @(negedge clk_sys);
        // Idle bus shows inverted values so a stale latch cannot pass
        req <= '{1'b0, k, ~p, ~d};
        n = 0;
        while (rsp.valid !== 1'b1 && n < 4)
        begin
            @(negedge clk_sys);
            n++;
        end
        r = rsp;
    endtask : xfer
endmodule : tmg_reader

// ===== test/tag_mirror_and_password_guard_tb.sv
// Self-checking bench for the page guard and text overlay
`timescale 1ns/1ps
module tag_mirror_and_password_guard_tb;
    logic clk_sys, rst, sessionAuthed, guardLocked, tapCounterEnable;
    logic [2:0] failCount;
    logic [7:0] firstGuardedPage, mp;
    logic [55:0] uidBytes;
    logic [23:0] tapCount;
    logic [31:0] key, mem [64];
    logic [1:0] sel, mb;
    logic hideCnt, authed;
    logic [11:0] cfgs [6];
    tmg_pkg::tmg_req_s req;
    tmg_pkg::tmg_rsp_s rsp, r;
    int n_errors = 0;
    int tests_run = 0;
    // Signature value is arbitrary
    localparam logic [255:0] SIG =
        256'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0_1122_3344_5566_7788_99AA_BBCC_DDEE_FF00;
    tmg_guard #(.SIGNATURE(SIG)) i_tmg_guard (.clk_sys(clk_sys), .rst(rst), .req(req),
        .uidBytes(uidBytes), .tapCount(tapCount), .rsp(rsp), .sessionAuthed(sessionAuthed),
        .guardLocked(guardLocked), .failCount(failCount),
        .tapCounterEnable(tapCounterEnable), .firstGuardedPage(firstGuardedPage));
    tmg_reader i_tmg_reader (.clk_sys(clk_sys), .req(req), .rsp(rsp));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? 8'h30 + n : 8'h37 + n;
    endfunction : hx
    function automatic logic [31:0] view(input logic [7:0] p);
        logic [31:0] w;
        int k;
        int q;
        w = (p == 8'h2B || p == 8'h2C) ? 32'h0 : mem[p];
        for (int i = 0; i < 4; i++)
        begin
            k = p * 4 + i - mp * 4 - mb;
            q = k - 15;
            if (sel == 2'h3 && mp > 8'h03 && mp * 4 + mb + 21 <= 160 && k >= 0 && k < 21)
            begin
                if (k < 14)
                    w[8*i +: 8] = hx(k[0] ? uidBytes[8*(k/2) +: 4] : uidBytes[8*(k/2)+4 +: 4]);
                else if (k == 14)
                    w[8*i +: 8] = 8'h78;
                else if (!hideCnt || authed)
                    w[8*i +: 8] = hx(q[0] ? tapCount[16-8*(q/2) +: 4] : tapCount[20-8*(q/2) +: 4]);
            end
        end
        return w;
    endfunction : view
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic op(input tmg_pkg::tmg_cmd_e k, input logic [7:0] p, input logic [31:0] d);
        i_tmg_reader.xfer(k, p, d, r);
        check(32'(r.valid), 32'h1);
    endtask : op
    task automatic wr(input logic [7:0] p, input logic [31:0] d, input logic e);
        op(tmg_pkg::CMD_WRITE, p, d);
        check(32'(r.ack), 32'(e));
        if (e)
            mem[p] = d;
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic e);
        op(tmg_pkg::CMD_READ, p, 32'h0);
        check(32'(r.ack), 32'(e));
        check(e ? r.data : 32'(r.nak), e ? view(p) : 32'h0);
    endtask : rd
    task automatic key_try(input logic [31:0] d, input logic e, input logic [2:0] f);
        op(tmg_pkg::CMD_KEY, 8'h00, d);
        check(32'(r.ack), 32'(e));
        check(32'(failCount), 32'(f));
        authed = e;
    endtask : key_try
    task automatic setm(input logic [1:0] s, input logic [7:0] p, input logic [1:0] b,
        input logic [7:0] g);
        wr(8'h29, {g, p, 8'h00, s, b, 4'h0}, 1'b1);
        sel = s;
        mp = p;
        mb = b;
    endtask : setm
    task automatic seta(input logic l, input logic f, input logic g, input logic [2:0] lim);
        wr(8'h2A, {24'h0, l, f, 2'h1, g, lim}, 1'b1);
        hideCnt = g;
    endtask : seta
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        #400000;
        n_errors++;
        test_done();
    end
    initial
    begin
        void'($urandom(6));
        rst = 1'b1;
        uidBytes = 56'({$urandom, $urandom});
        tapCount = 24'($urandom);
        {sel, mp, mb, hideCnt, authed} = '0;
        key = $urandom;
        cfgs = '{{2'h3, 8'h0C, 2'h1}, {2'h3, 8'h04, 2'h0}, {2'h3, 8'h22, 2'h2},
            {2'h2, 8'h0C, 2'h1}, {2'h3, 8'h03, 2'h1}, {2'h3, 8'h24, 2'h0}};
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check(32'(firstGuardedPage), 32'hFF);
        check(32'(tapCounterEnable), 32'h0);
        key_try(32'h1234_5678, 1'b0, 3'h0);
        for (int p = 4; p < 40; p++)
            wr(8'(p), $urandom, 1'b1);
        foreach (cfgs[c])
        begin
            setm(cfgs[c][11:10], cfgs[c][9:2], cfgs[c][1:0], 8'hFF);
            for (int p = 4; p < 40; p++)
                rd(8'(p), 1'b1);
        end
        $display("test overlay done");
        for (int w = 0; w < 8; w++)
        begin
            op(tmg_pkg::CMD_SIG, 8'(w), 32'h0);
            check(r.data, SIG[32*w +: 32]);
        end
        $display("test signature done");
        setm(2'h3, 8'h0C, 2'h1, 8'hFF);
        seta(1'b0, 1'b0, 1'b1, 3'h0);
        check(32'(tapCounterEnable), 32'h1);
        rd(8'h10, 1'b1);
        wr(8'h2B, key, 1'b1);
        wr(8'h2C, {16'h0, key[31:16]}, 1'b1);
        setm(2'h3, 8'h0C, 2'h1, 8'h2B);
        wr(8'h2B, ~key, 1'b0);
        rd(8'h2B, 1'b1);
        rd(8'h2C, 1'b1);
        key_try(key, 1'b1, 3'h0);
        check(r.data, {16'h0, key[31:16]});
        op(tmg_pkg::CMD_LEGACY, 8'h2C, {16'h0, key[31:16]});
        check(32'(r.ack), 32'h1);
        rd(8'h10, 1'b1);
        rd(8'h11, 1'b1);
        $display("test key done");
        setm(2'h3, 8'h0C, 2'h1, 8'h10);
        seta(1'b1, 1'b0, 1'b1, 3'h2);
        check(32'(firstGuardedPage), 32'h10);
        op(tmg_pkg::CMD_DESEL, 8'h00, 32'h0);
        authed = 1'b0;
        rd(8'h10, 1'b0);
        rd(8'h0F, 1'b1);
        wr(8'h2B, ~key, 1'b0);
        wr(8'h2A, 32'h0, 1'b0);
        key_try(~key, 1'b0, 3'h1);
        key_try(~key, 1'b0, 3'h2);
        key_try(key, 1'b1, 3'h0);
        seta(1'b0, 1'b1, 1'b1, 3'h2);
        op(tmg_pkg::CMD_DESEL, 8'h00, 32'h0);
        authed = 1'b0;
        rd(8'h10, 1'b1);
        wr(8'h10, 32'h0, 1'b0);
        key_try(key, 1'b1, 3'h0);
        key = ~key;
        wr(8'h2B, key, 1'b1);
        wr(8'h2A, 32'h0, 1'b0);
        $display("test guard done");
        key_try(~key, 1'b0, 3'h1);
        key_try(~key, 1'b0, 3'h2);
        key_try(~key, 1'b0, 3'h2);
        check(32'(guardLocked), 32'h1);
        key_try(key, 1'b0, 3'h2);
        check(32'(r.nak), 32'h4);
        $display("test lockout done");
        test_done();
    end
endmodule : tag_mirror_and_password_guard_tb
